// ===== dfw_cfg.svh
// offsets, field positions, reset values and bus constants of the wrap and flag bytes
//
// Behaviour
// - optical forward with optical wrap sends received optical data to both outputs.
// - writing optical forward sets optical wrap and clears all other wrap bits.
// - optical wrap high loops received optical data to transmit optical output.
// - writing optical wrap clears every other bit of the wrap byte.
// - electrical forward with electrical wrap sends transmit data to both outputs.
// - writing electrical forward sets electrical wrap and clears all other bits.
// - electrical wrap high loops transmit electrical data to receive electrical output.
// - writing electrical wrap clears every other bit of the wrap byte.
// - alarm byte 112 bits 7/6 flag temperature above high, below low alarm.
// - alarm byte 112 bits 5/4 flag supply voltage above high, below low alarm.
// - alarm byte 112 bits 3/2 flag laser bias above high, below low alarm.
// - alarm byte 112 bits 1/0 flag transmit power above high, below low alarm.
// - alarm byte 113 bits 7/6 flag receive power; bits 5..0 reserved.
// - warning byte 116 bits 7/6 flag temperature above high, below low warning.
// - warning byte 116 bits 5/4 flag supply voltage high and low warning.
// - warning byte 116 bits 3/2 flag laser bias high and low warning.
// - warning byte 116 bits 1/0 flag transmit power high and low warning.
// - warning byte 117 bits 7/6 flag receive power; bits 5..0 reserved.
// - temperature compares as 16-bit signed two's complement, 1/256 degree steps.
// - supply voltage compares as 16-bit unsigned, 100 microvolt steps.
`ifndef DFW_CFG_SVH
`define DFW_CFG_SVH

// ----------------------------------------------------------------------------
// register map and bus address
// ----------------------------------------------------------------------------
`define DFW_DEV_ADDR 7'h51
`define DFW_OFF_WRAP 8'h6f
`define DFW_OFF_ALARM_LO 8'h70
`define DFW_OFF_ALARM_RX 8'h71
`define DFW_OFF_WARN_LO 8'h74
`define DFW_OFF_WARN_RX 8'h75
`define DFW_RSVD_BYTE 8'h00

// ----------------------------------------------------------------------------
// wrap byte fields and write results
// ----------------------------------------------------------------------------
`define DFW_WRAP_OFWD_BIT 3
`define DFW_WRAP_OPT_BIT 2
`define DFW_WRAP_EFWD_BIT 1
`define DFW_WRAP_ELEC_BIT 0
`define DFW_WRAP_RESET 4'h0
`define DFW_WRAP_OFWD_VAL 4'hc
`define DFW_WRAP_OPT_VAL 4'h4
`define DFW_WRAP_EFWD_VAL 4'h3
`define DFW_WRAP_ELEC_VAL 4'h1
`define DFW_WRAP_RSVD 4'h0

// ----------------------------------------------------------------------------
// monitored channels and flag bit positions
// ----------------------------------------------------------------------------
`define DFW_VAL_W 16
`define DFW_NCH 5
`define DFW_CH_TEMP 0
`define DFW_CH_VCC 1
`define DFW_CH_BIAS 2
`define DFW_CH_TXP 3
`define DFW_CH_RXP 4
`define DFW_HI_BIT(ch) (7 - 2 * (ch))
`define DFW_LO_BIT(ch) (6 - 2 * (ch))
`define DFW_FLAG_RSVD 6'h00

`endif

// ===== dfw_pkg.sv
// types shared by the wrap and flag logic
`include "dfw_cfg.svh"
package dfw_pkg;

  typedef logic [`DFW_NCH-1:0][`DFW_VAL_W-1:0] dfw_meas_t;

  typedef struct packed {
    logic [`DFW_VAL_W-1:0] hi_alarm;
    logic [`DFW_VAL_W-1:0] lo_alarm;
    logic [`DFW_VAL_W-1:0] hi_warn;
    logic [`DFW_VAL_W-1:0] lo_warn;
  } dfw_thr_s;

  typedef dfw_thr_s [`DFW_NCH-1:0] dfw_thr_arr_t;

  typedef struct packed {
    logic hi_alarm;
    logic lo_alarm;
    logic hi_warn;
    logic lo_warn;
  } dfw_flag4_s;

  typedef struct packed {
    logic tx_opt_from_rx_opt;
    logic rx_elec_from_tx_elec;
    logic tx_opt_on;
    logic rx_elec_on;
  } dfw_route_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WADDR, ST_WADDR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } dfw_i2c_state_e;

endpackage

// ===== dfw_compare.sv
// one monitored value against its four thresholds, registered flags
`timescale 1ns/10ps
`include "dfw_cfg.svh"
module dfw_compare #(
  parameter int WIDTH = `DFW_VAL_W,
  parameter bit SIGNED = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] hi_alarm,
  input wire logic [WIDTH-1:0] lo_alarm,
  input wire logic [WIDTH-1:0] hi_warn,
  input wire logic [WIDTH-1:0] lo_warn,
  output dfw_pkg::dfw_flag4_s flags
);
  import dfw_pkg::*;

  if (WIDTH < 2) begin : g_chk
    $error("dfw_compare: WIDTH must be at least 2");
  end

  wire logic above_ha;
  wire logic below_la;
  wire logic above_hw;
  wire logic below_lw;
  dfw_flag4_s flags_next;

  // signed only for temperature, all other channels unsigned
  assign above_ha = SIGNED ? ($signed(value) > $signed(hi_alarm)) :
                    (value > hi_alarm);
  assign below_la = SIGNED ? ($signed(value) < $signed(lo_alarm)) :
                    (value < lo_alarm);
  assign above_hw = SIGNED ? ($signed(value) > $signed(hi_warn)) : (value > hi_warn);
  assign below_lw = SIGNED ? ($signed(value) < $signed(lo_warn)) : (value < lo_warn);
  assign flags_next = '{hi_alarm: above_ha, lo_alarm: below_la, hi_warn: above_hw,
                        lo_warn: below_lw};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= flags_next;
    end
  end

endmodule

// ===== dfw_wrap_ctl.sv
// wrap control byte: write shaping and data path steering
`timescale 1ns/10ps
`include "dfw_cfg.svh"
module dfw_wrap_ctl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] ctl,
  output dfw_pkg::dfw_route_s route
);
  import dfw_pkg::*;

  logic [3:0] ctl_reg;
  wire logic [3:0] ctl_next;
  wire dfw_route_s route_next;

  // ----------------------------------------------------------------------------
  // write shaping: forward modes win, optical before electrical
  // ----------------------------------------------------------------------------
  assign ctl_next = wr_data[`DFW_WRAP_OFWD_BIT] ? `DFW_WRAP_OFWD_VAL :
                    wr_data[`DFW_WRAP_EFWD_BIT] ? `DFW_WRAP_EFWD_VAL :
                    wr_data[`DFW_WRAP_OPT_BIT] ? `DFW_WRAP_OPT_VAL :
                    wr_data[`DFW_WRAP_ELEC_BIT] ? `DFW_WRAP_ELEC_VAL :
                    `DFW_WRAP_RESET;

  // ----------------------------------------------------------------------------
  // steering
  // ----------------------------------------------------------------------------
  assign route_next.tx_opt_from_rx_opt = ctl_next[`DFW_WRAP_OPT_BIT];
  assign route_next.rx_elec_from_tx_elec = ctl_next[`DFW_WRAP_ELEC_BIT];
  // optical output stays live unless electrical wrap runs without forward
  assign route_next.tx_opt_on = !ctl_next[`DFW_WRAP_ELEC_BIT] ||
                                ctl_next[`DFW_WRAP_EFWD_BIT];
  // electrical output stays live unless optical wrap runs without forward
  assign route_next.rx_elec_on = !ctl_next[`DFW_WRAP_OPT_BIT] ||
                                 ctl_next[`DFW_WRAP_OFWD_BIT];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_reg <= `DFW_WRAP_RESET;
      route <= '{tx_opt_from_rx_opt: 1'b0, rx_elec_from_tx_elec: 1'b0,
                 tx_opt_on: 1'b1, rx_elec_on: 1'b1};
    end else if (wr_en) begin
      ctl_reg <= ctl_next;
      route <= route_next;
    end
  end

  assign ctl = {`DFW_WRAP_RSVD, ctl_reg};

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  property p_ofwd_write;
    @(posedge mclk) disable iff (rst)
    wr_en && wr_data[3] |=> ctl == 8'h0c && route.tx_opt_from_rx_opt && route.rx_elec_on;
  endproperty
  a_ofwd_write: assert property (p_ofwd_write) else $error("optical forward write wrong");

  property p_optical_loopback_write;
    @(posedge mclk) disable iff (rst)
    wr_en && wr_data[2] && !wr_data[3] && !wr_data[1] |=> ctl == 8'h04 && !route.rx_elec_on;
  endproperty
  a_optical_loopback_write: assert property (p_optical_loopback_write) else $error("optical wrap write wrong");

  property p_efwd_write;
    @(posedge mclk) disable iff (rst)
    wr_en && wr_data[1] && !wr_data[3] |=> ctl == 8'h03 && route.tx_opt_on;
  endproperty
  a_efwd_write: assert property (p_efwd_write)
    else $error("electrical forward write wrong");

  property p_electrical_loopback_write;
    @(posedge mclk) disable iff (rst)
    wr_en && wr_data[3:0] == 4'h1 |=> ctl == 8'h01 && !route.tx_opt_on;
  endproperty
  a_electrical_loopback_write: assert property (p_electrical_loopback_write) else $error("electrical wrap write wrong");

  property p_route_opt;
    @(posedge mclk) disable iff (rst)
    ctl[2] |-> route.tx_opt_from_rx_opt && !route.rx_elec_from_tx_elec &&
      route.rx_elec_on == ctl[3];
  endproperty
  a_route_opt: assert property (p_route_opt) else $error("optical steering wrong");

  property p_route_elec;
    @(posedge mclk) disable iff (rst)
    ctl[0] |-> route.rx_elec_from_tx_elec && route.tx_opt_on == ctl[1];
  endproperty
  a_route_elec: assert property (p_route_elec) else $error("electrical steering wrong");

  property p_hold;
    @(posedge mclk) disable iff (rst)
    !wr_en |=> $stable(ctl) && $stable(route);
  endproperty
  a_hold: assert property (p_hold) else $error("wrap byte changed without write");

endmodule

// ===== dfw_top.sv
// two-wire management slave holding the wrap control and diagnostic flag bytes
`timescale 1ns/10ps
`include "dfw_cfg.svh"
module dfw_top #(
  parameter logic [6:0] DEV_ADDR = `DFW_DEV_ADDR
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input dfw_pkg::dfw_meas_t meas,
  input dfw_pkg::dfw_thr_arr_t thr,
  output dfw_pkg::dfw_route_s route
);
  import dfw_pkg::*;

  if (DEV_ADDR == 7'h00) begin : g_chk
    $error("dfw_top: DEV_ADDR 0 is the general call address");
  end

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  dfw_i2c_state_e state_reg;
  dfw_i2c_state_e state_next;
  logic scl_reg;
  logic sda_reg;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic oe_reg;
  logic oe_next;
  logic rw_reg;
  logic rw_next;
  logic nack_reg;
  logic nack_next;
  logic wr_stb;
  wire logic start_cond;
  wire logic stop_cond;
  wire logic scl_rise;
  wire logic scl_fall;
  wire logic byte_done;
  wire logic [7:0] ptr_inc;
  wire logic [7:0] rd_data;
  wire logic [7:0] wrap_ctl;
  wire logic wrap_wr;
  wire logic [7:0] alarm_lo_byte;
  wire logic [7:0] warn_lo_byte;
  wire logic [7:0] alarm_rx_byte;
  wire logic [7:0] warn_rx_byte;
  wire dfw_flag4_s [`DFW_NCH-1:0] flags;

  // ----------------------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------------------
  assign start_cond = scl_reg && scl_i && sda_reg && !sda_i;
  assign stop_cond = scl_reg && scl_i && !sda_reg && sda_i;
  assign scl_rise = !scl_reg && scl_i;
  assign scl_fall = scl_reg && !scl_i;
  assign byte_done = bit_reg == 4'h8;
  assign ptr_inc = ptr_reg + 8'h01;

  // ----------------------------------------------------------------------------
  // threshold comparators and flag bytes
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < `DFW_NCH; i++) begin : g_ch
    dfw_compare #(
      .WIDTH(`DFW_VAL_W),
      .SIGNED(i == `DFW_CH_TEMP)
    ) u_cmp (
      .mclk(mclk),
      .rst(rst),
      .value(meas[i]),
      .hi_alarm(thr[i].hi_alarm),
      .lo_alarm(thr[i].lo_alarm),
      .hi_warn(thr[i].hi_warn),
      .lo_warn(thr[i].lo_warn),
      .flags(flags[i])
    );
    if (i < `DFW_CH_RXP) begin : g_lo
      // temperature, supply, bias and transmit power share the low group bytes
      assign alarm_lo_byte[`DFW_HI_BIT(i)] = flags[i].hi_alarm;
      assign alarm_lo_byte[`DFW_LO_BIT(i)] = flags[i].lo_alarm;
      assign warn_lo_byte[`DFW_HI_BIT(i)] = flags[i].hi_warn;
      assign warn_lo_byte[`DFW_LO_BIT(i)] = flags[i].lo_warn;
    end
  end

  assign alarm_rx_byte = {flags[`DFW_CH_RXP].hi_alarm, flags[`DFW_CH_RXP].lo_alarm,
                          `DFW_FLAG_RSVD};
  assign warn_rx_byte = {flags[`DFW_CH_RXP].hi_warn, flags[`DFW_CH_RXP].lo_warn,
                         `DFW_FLAG_RSVD};

  // ----------------------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ----------------------------------------------------------------------------
  assign rd_data = (ptr_reg == `DFW_OFF_WRAP) ? wrap_ctl :
                   (ptr_reg == `DFW_OFF_ALARM_LO) ? alarm_lo_byte :
                   (ptr_reg == `DFW_OFF_ALARM_RX) ? alarm_rx_byte :
                   (ptr_reg == `DFW_OFF_WARN_LO) ? warn_lo_byte :
                   (ptr_reg == `DFW_OFF_WARN_RX) ? warn_rx_byte :
                   `DFW_RSVD_BYTE;

  // only the wrap byte takes writes; flag bytes drop them
  assign wrap_wr = wr_stb && (ptr_reg == `DFW_OFF_WRAP);

  dfw_wrap_ctl u_wrap (
    .mclk(mclk),
    .rst(rst),
    .wr_en(wrap_wr),
    .wr_data(shift_reg),
    .ctl(wrap_ctl),
    .route(route)
  );

  // ----------------------------------------------------------------------------
  // serial slave sequencing
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    wr_stb = 1'b0;
    if (stop_cond) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (start_cond) begin
      state_next = ST_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      if (state_reg == ST_ADDR || state_reg == ST_WADDR || state_reg == ST_WDATA ||
          state_reg == ST_RDATA) begin
        bit_next = bit_reg + 4'h1;
      end
      if (state_reg == ST_RDATA_ACK) begin
        nack_next = sda_i;
      end
    end else if (scl_fall) begin
      case (state_reg)
        ST_ADDR: begin
          if (byte_done) begin
            if (shift_reg[7:1] == DEV_ADDR) begin
              oe_next = 1'b1;
              rw_next = shift_reg[0];
              state_next = ST_ADDR_ACK;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_next = 4'h0;
          if (rw_reg) begin
            tx_next = {rd_data[6:0], 1'b0};
            oe_next = !rd_data[7];
            state_next = ST_RDATA;
          end else begin
            oe_next = 1'b0;
            state_next = ST_WADDR;
          end
        end
        ST_WADDR: begin
          if (byte_done) begin
            oe_next = 1'b1;
            ptr_next = shift_reg;
            state_next = ST_WADDR_ACK;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            oe_next = 1'b1;
            wr_stb = 1'b1;
            ptr_next = ptr_inc;
            state_next = ST_WDATA_ACK;
          end
        end
        ST_WADDR_ACK, ST_WDATA_ACK: begin
          oe_next = 1'b0;
          bit_next = 4'h0;
          state_next = ST_WDATA;
        end
        ST_RDATA: begin
          if (byte_done) begin
            oe_next = 1'b0;
            ptr_next = ptr_inc;
            state_next = ST_RDATA_ACK;
          end else begin
            oe_next = !tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK: begin
          if (nack_reg) begin
            state_next = ST_IDLE;
          end else begin
            bit_next = 4'h0;
            tx_next = {rd_data[6:0], 1'b0};
            oe_next = !rd_data[7];
            state_next = ST_RDATA;
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      shift_reg <= 8'h00;
    end else begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
      if (scl_rise) begin
        shift_reg <= {shift_reg[6:0], sda_i};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
    end
  end

  // open drain: the pin only ever pulls low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oe_reg <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      oe_reg <= oe_next;
      sda_o <= 1'b0;
    end
  end

  assign sda_oe = oe_reg;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_temp_hi_alarm;
    $signed(meas[0]) > $signed(thr[0].hi_alarm) |=> alarm_lo_byte[7];
  endproperty
  a_temp_hi_alarm: assert property (p_temp_hi_alarm) else $error("temp high alarm missed");

  property p_temp_sign;
    meas[0][15] && !thr[0].hi_alarm[15] && !thr[0].hi_warn[15] |=>
      !alarm_lo_byte[7] && !warn_lo_byte[7];
  endproperty
  a_temp_sign: assert property (p_temp_sign) else $error("negative temp flagged high");

  property p_vcc_lo_alarm;
    meas[1] < thr[1].lo_alarm |=> alarm_lo_byte[4] && !warn_rx_byte[0];
  endproperty
  a_vcc_lo_alarm: assert property (p_vcc_lo_alarm) else $error("vcc low alarm missed");

  property p_vcc_unsigned;
    meas[1][15] && !thr[1].hi_alarm[15] |=> alarm_lo_byte[5];
  endproperty
  a_vcc_unsigned: assert property (p_vcc_unsigned) else $error("vcc compared signed");

  property p_bias_alarms;
    meas[2] > thr[2].hi_alarm ##1 meas[2] < thr[2].lo_alarm |=>
      alarm_lo_byte[2] && !alarm_lo_byte[3];
  endproperty
  a_bias_alarms: assert property (p_bias_alarms) else $error("bias alarm tracking wrong");

  property p_txp_flags;
    meas[3] < thr[3].lo_warn |=> warn_lo_byte[0] ##1
      (alarm_lo_byte[1] == ($past(meas[3]) > $past(thr[3].hi_alarm)));
  endproperty
  a_txp_flags: assert property (p_txp_flags) else $error("tx power flag wrong");

  property p_rx_alarm;
    meas[4] > thr[4].hi_alarm |=> alarm_rx_byte[7] && alarm_rx_byte[5:0] == 6'h00;
  endproperty
  a_rx_alarm: assert property (p_rx_alarm) else $error("rx power alarm wrong");

  property p_rx_warn;
    meas[4] < thr[4].lo_warn |=> warn_rx_byte == {1'b0, 1'b1, 6'h00} || warn_rx_byte[7];
  endproperty
  a_rx_warn: assert property (p_rx_warn) else $error("rx power warning wrong");

  property p_temp_lo_warn;
    $signed(meas[0]) < $signed(thr[0].lo_warn) |=> warn_lo_byte[6];
  endproperty
  a_temp_lo_warn: assert property (p_temp_lo_warn) else $error("temp low warning missed");

  sequence s_wrap_data_byte;
    state_reg == ST_WDATA && byte_done && scl_fall && !start_cond && !stop_cond &&
      ptr_reg == 8'h6f;
  endsequence

  property p_bus_ofwd;
    s_wrap_data_byte ##0 shift_reg[3] |=> wrap_ctl == 8'h0c ##1 sda_oe;
  endproperty
  a_bus_ofwd: assert property (p_bus_ofwd) else $error("bus write of forward bit wrong");

  sequence s_flag_data_byte;
    state_reg == ST_WDATA && byte_done && scl_fall && ptr_reg == 8'h70;
  endsequence

  property p_flag_write_ignored;
    s_flag_data_byte |=> $stable(wrap_ctl);
  endproperty
  a_flag_write_ignored: assert property (p_flag_write_ignored)
    else $error("flag write leaked");

endmodule

// ===== dfw_host_model.sv
// two-wire host model driving the clock and an open-drain data line
`timescale 1ns/10ps
module dfw_host_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // data moves only while the clock is low, sampled with the clock high
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
  endtask
  // start and repeated start: data falls while the clock is high
  task automatic start();
    tick(1);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nack);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// ===== test_diag_flags_wrap_control.sv
// self-checking bench for the wrap control and flag bytes
`timescale 1ns/10ps
`include "dfw_cfg.svh"
module test_diag_flags_wrap_control;
  import dfw_pkg::*;
  logic mclk;
  logic rst;
  wire logic scl;
  wire logic sda_low;
  wire logic sda_oe;
  wire logic sda_o;
  wire logic sda;
  dfw_meas_t meas;
  dfw_thr_arr_t thr;
  dfw_route_s route;
  int fails;
  int checks_done;
  logic nack;
  logic [47:0] q;
  logic [7:0] wv [7] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'hff, 8'h05, 8'hf0};
  logic [7:0] wr_exp [7] = '{8'h0c, 8'h04, 8'h03, 8'h01, 8'h0c, 8'h04, 8'h00};
  logic [3:0] rt_exp [7] = '{4'hb, 4'ha, 4'h7, 4'h5, 4'hb, 4'ha, 4'h3};
  logic [15:0] vals [7] = '{16'h03e9, 16'h0063, 16'h03b6, 16'h01f4, 16'h0096, 16'h03e8, 16'hfff0};
  // the wire is pulled up unless the host pulls it or the device drives its data value
  assign sda = ~sda_low & (~sda_oe | sda_o);
  dfw_top dut (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .meas(meas), .thr(thr), .route(route));
  dfw_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [6:0] da, input logic [7:0] p, input logic [7:0] d);
    logic n1;
    logic n2;
    logic n3;
    host.start();
    host.wbyte({da, 1'b0}, n1);
    host.wbyte(p, n2);
    host.wbyte(d, n3);
    host.stop();
    nack = n1 | n2 | n3;
  endtask
  // addressed read of n bytes from pointer p, first byte ends up highest in q
  task automatic reg_rd(input logic [7:0] p, input int n);
    logic n1;
    logic [7:0] b;
    host.start();
    host.wbyte({`DFW_DEV_ADDR, 1'b0}, n1);
    host.wbyte(p, n1);
    host.start();
    host.wbyte({`DFW_DEV_ADDR, 1'b1}, n1);
    q = '0;
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, b);
      q = {q[39:0], b};
    end
    host.stop();
  endtask
  // thresholds: high alarm 1000, low alarm 100, high warning 900, low warning 200
  function automatic logic [3:0] exp4(input int ch, input logic [15:0] v);
    logic signed [16:0] x;
    x = (ch == `DFW_CH_TEMP) ? {v[15], v} : {1'b0, v};
    return {x > 17'sd1000, x < 17'sd100, x > 17'sd900, x < 17'sd200};
  endfunction
  initial begin
    mclk = 1'b0;
    forever begin
      #50 mclk = ~mclk;
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    stop_test();
  end
  initial begin
    logic [15:0] al;
    logic [15:0] wn;
    logic [3:0] a;
    rst = 1'b1;
    fails = 0;
    checks_done = 0;
    for (int i = 0; i < `DFW_NCH; i++) begin
      meas[i] = 16'h01f4;
      thr[i] = '{16'h03e8, 16'h0064, 16'h0384, 16'h00c8};
    end
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk("route after reset", 48'h3, {44'h0, route});
    reg_rd(`DFW_OFF_WRAP, 1);
    chk("wrap after reset", 48'h0, q);
    reg_wr(`DFW_DEV_ADDR + 7'h1, `DFW_OFF_WRAP, 8'h08);
    chk("foreign address nack", 48'h1, {47'h0, nack});
    chk("route kept", 48'h3, {44'h0, route});
    for (int i = 0; i < 7; i++) begin
      reg_wr(`DFW_DEV_ADDR, `DFW_OFF_WRAP, wv[i]);
      chk("write ack", 48'h0, {47'h0, nack});
      reg_rd(`DFW_OFF_WRAP, 1);
      chk("wrap byte", {40'h0, wr_exp[i]}, q);
      chk("route", {44'h0, rt_exp[i]}, {44'h0, route});
    end
    // flag bytes are read-only, this write must leave no trace
    reg_wr(`DFW_DEV_ADDR, `DFW_OFF_ALARM_LO, 8'hff);
    chk("flag write ack", 48'h0, {47'h0, nack});
    reg_rd(`DFW_OFF_WRAP, 1);
    chk("wrap after flag write", 48'h0, q);
    for (int ch = 0; ch < `DFW_NCH; ch++) begin
      for (int j = 0; j < 7; j++) begin
        @(posedge mclk);
        #1;
        meas[ch] = vals[j];
        a = exp4(ch, vals[j]);
        al = '0;
        wn = '0;
        al[15 - 2 * ch] = a[3];
        al[14 - 2 * ch] = a[2];
        wn[15 - 2 * ch] = a[1];
        wn[14 - 2 * ch] = a[0];
        reg_rd(`DFW_OFF_ALARM_LO, 6);
        chk("alarm bytes", {32'h0, al}, {32'h0, q[47:32]});
        chk("unmapped bytes", 48'h0, {32'h0, q[31:16]});
        chk("warning bytes", {32'h0, wn}, {32'h0, q[15:0]});
      end
      meas[ch] = 16'h01f4;
    end
    stop_test();
  end
endmodule
